// ---- hw/anreg_status_id.sv ----
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Lower next-page read snapshots upper partner word
// - Upper word read returns the held snapshot
// - Partner page request sets latch-high bit 8
// - Latch-high bit 8 stays set until host reads 0x8001
// - Incompatible link bit updates entering good check
// - Role field bits 6:5 encode resolution outcome
// - Technology field bits 4:1: 0 none, 1 T1L
// - Bit 0 high after negotiation transmission completes
// - Link good needs no established link
// - Extra status at 0x8001, AN device, resets zero
// - Vendor device offset 2 shows identifier bits 3-18
// - Offset 3: id bits, model, revision fields
module anreg_status_id #(
	parameter logic [15:0] VENDOR_ID_HIGH = 16'h1234, // Arbitrary value
	parameter logic [5:0]  VENDOR_ID_LOW  = 6'h15,    // Arbitrary value
	parameter logic [5:0]  MODEL_NUMBER   = 6'h2a,    // Arbitrary value
	parameter logic [3:0]  REVISION       = 4'h3      // Arbitrary value
) (
	input  wire logic                          ref_clk,
	input  wire logic                          sys_rst,
	// Management access, already deframed by the MDIO engine
	input  wire logic                          mgmt_rd,
	input  wire logic                          mgmt_wr,
	input  wire logic [anreg_pkg::DEVAD_W-1:0] mgmt_devad,
	input  wire logic [anreg_pkg::ADDR_W-1:0]  mgmt_addr,
	input  wire logic [anreg_pkg::DATA_W-1:0]  mgmt_wdata,
	output logic      [anreg_pkg::DATA_W-1:0]  mgmt_rdata,
	output logic                               mgmt_hit,
	// Arbitration side, same clock
	input  wire logic [anreg_pkg::DATA_W-1:0]  partner_unformatted_field_two,
	input  wire logic                          partner_page_request_evt,
	input  wire logic                          good_check_entry,
	input  wire logic                          priority_incompatible,
	input  wire logic [1:0]                    role_resolution_in,
	input  wire logic [3:0]                    common_technology_in,
	input  wire logic                          negotiation_link_good_in,
	output logic                               partner_page_request_seen,
	output logic                               incompatible_link_flag
);
	import anreg_pkg::*;

	logic [DATA_W-1:0] rdata_ff;
	logic [DATA_W-1:0] nxt_rdata;
	logic              hit_ff;
	logic              nxt_hit;
	logic              incompat_ff;
	logic              nxt_incompat;
	logic [1:0]        role_ff;
	logic [3:0]        tech_ff;
	logic              good_ff;

	wire logic [DATA_W-1:0] held_upper;
	wire logic              page_seen;
	wire logic              sel_an;
	wire logic              sel_vend;
	wire logic              hit_lower;
	wire logic              hit_upper;
	wire logic              hit_extra;
	wire logic              hit_id_high;
	wire logic              hit_id_low;
	wire logic              any_hit;
	wire logic [DATA_W-1:0] extra_word;
	wire logic [DATA_W-1:0] id_low_word;
	wire logic [DATA_W-1:0] read_word;

	function automatic logic match(
		input logic [DEVAD_W-1:0] dv,
		input logic [ADDR_W-1:0]  ad,
		input logic [DEVAD_W-1:0] want_dv,
		input logic [ADDR_W-1:0]  want_ad
	);
		match = (dv == want_dv) && (ad == want_ad);
	endfunction

	assign hit_lower = match(mgmt_devad, mgmt_addr, DEVAD_AN,
		OFS_PARTNER_NP_LOWER);
	assign hit_upper = match(mgmt_devad, mgmt_addr, DEVAD_AN,
		OFS_PARTNER_NP_UPPER);
	assign hit_extra = match(mgmt_devad, mgmt_addr, DEVAD_AN,
		OFS_EXTRA_STATUS);
	assign hit_id_high = match(mgmt_devad, mgmt_addr, DEVAD_VEND,
		OFS_VENDOR_ID_HIGH);
	assign hit_id_low = match(mgmt_devad, mgmt_addr, DEVAD_VEND,
		OFS_VENDOR_ID_LOW);
	assign sel_an = hit_upper | hit_extra;
	assign sel_vend = hit_id_high | hit_id_low;
	assign any_hit = sel_an | sel_vend;

	// Lower word itself lives elsewhere; we only watch its read strobe
	anreg_snapshot #(
		.WIDTH(DATA_W)
	) u_snapshot (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.capture  (mgmt_rd & hit_lower),
		.live_word(partner_unformatted_field_two),
		.held_word(held_upper)
	);

	anreg_latch_high u_page_seen (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.event_in(partner_page_request_evt),
		.read_clr(mgmt_rd & hit_extra),
		.flag    (page_seen)
	);

	// Value only moves on good-check entry, else held
	assign nxt_incompat = good_check_entry ? priority_incompatible
		: incompat_ff;

	assign extra_word = {7'h00, page_seen, incompat_ff, role_ff, tech_ff,
		good_ff};
	assign id_low_word = {VENDOR_ID_LOW, MODEL_NUMBER, REVISION};

	assign read_word = hit_upper   ? held_upper :
	                   hit_extra   ? extra_word :
	                   hit_id_high ? VENDOR_ID_HIGH :
	                   hit_id_low  ? id_low_word :
	                                 RD_UNMAPPED;

	// Read data stand registered until the next read; writes update only the hit flag
	assign nxt_rdata = mgmt_rd ? read_word : rdata_ff;
	assign nxt_hit = (mgmt_rd | mgmt_wr) ? any_hit : hit_ff;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rdata_ff <= RD_UNMAPPED;
			hit_ff <= 1'b0;
		end else begin
			rdata_ff <= nxt_rdata;
			hit_ff <= nxt_hit;
		end
	end

	// Role, technology and link good follow resolution live; reset clears all to zero
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			incompat_ff <= RST_EXTRA_STATUS[POS_INCOMPAT];
			role_ff <= ANREG_ROLE_NOT_RUN;
			tech_ff <= TECH_NULL;
			good_ff <= RST_EXTRA_STATUS[POS_LINK_GOOD];
		end else begin
			incompat_ff <= nxt_incompat;
			role_ff <= role_resolution_in;
			// Reserved technology codes are passed as given
			tech_ff <= common_technology_in;
			// No link-up term here, unlike the base status done bit
			good_ff <= negotiation_link_good_in;
		end
	end

	assign mgmt_rdata = rdata_ff;
	assign mgmt_hit = hit_ff;
	assign partner_page_request_seen = page_seen;
	assign incompatible_link_flag = incompat_ff;

	wire logic unused_ok = &{1'b0, mgmt_wdata};
endmodule // anreg_status_id
`default_nettype wire

// ---- shared/anreg_pkg.sv ----
`default_nettype none
package anreg_pkg;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DEVAD_W = 5;

	// Management device addresses
	localparam logic [4:0] DEVAD_AN = 5'h07;
	localparam logic [4:0] DEVAD_VEND = 5'h1e;

	// Register offsets
	localparam logic [15:0] OFS_PARTNER_NP_LOWER = 16'h020b;
	localparam logic [15:0] OFS_PARTNER_NP_UPPER = 16'h020d;
	localparam logic [15:0] OFS_EXTRA_STATUS = 16'h8001;
	localparam logic [15:0] OFS_VENDOR_ID_HIGH = 16'h0002;
	localparam logic [15:0] OFS_VENDOR_ID_LOW = 16'h0003;

	// Extra status field positions
	localparam int unsigned POS_PAGE_SEEN = 8;
	localparam int unsigned POS_INCOMPAT = 7;
	localparam int unsigned POS_ROLE_LO = 5;
	localparam int unsigned POS_TECH_LO = 1;
	localparam int unsigned POS_LINK_GOOD = 0;

	// Second identifier word field positions
	localparam int unsigned POS_ID_LOW_BITS = 10;
	localparam int unsigned POS_MODEL = 4;
	localparam int unsigned POS_REV = 0;

	// Reset values
	localparam logic [15:0] RST_PARTNER_NP_UPPER = 16'h0000;
	localparam logic [15:0] RST_EXTRA_STATUS = 16'h0000;
	localparam logic [15:0] RD_UNMAPPED = 16'h0000;

	// Role resolution codes
	typedef enum logic [1:0] {
		ANREG_ROLE_NOT_RUN = 2'h0,
		ANREG_ROLE_FAULT = 2'h1,
		ANREG_ROLE_SLAVE = 2'h2,
		ANREG_ROLE_MASTER = 2'h3
	} anreg_role_t;

	// Common technology codes
	localparam logic [3:0] TECH_NULL = 4'h0;
	localparam logic [3:0] TECH_T1L = 4'h1;
endpackage
`default_nettype wire

// ---- hw/anreg_snapshot.sv ----
`timescale 1ns/1ps
`default_nettype none
// Upper next-page word holding register, loaded on a lower-word read
module anreg_snapshot #(
	parameter int unsigned WIDTH = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	input  wire logic             capture,
	input  wire logic [WIDTH-1:0] live_word,
	output logic      [WIDTH-1:0] held_word
);
	import anreg_pkg::*;

	logic [WIDTH-1:0] held_ff;
	logic [WIDTH-1:0] nxt_held;

	if (WIDTH != DATA_W) begin : g_chk
		$error("anreg_snapshot: WIDTH must equal DATA_W");
	end

	assign nxt_held = capture ? live_word : held_ff;
	assign held_word = held_ff;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			held_ff <= RST_PARTNER_NP_UPPER;
		end else begin
			held_ff <= nxt_held;
		end
	end
endmodule // anreg_snapshot
`default_nettype wire

// ---- hw/anreg_latch_high.sv ----
`timescale 1ns/1ps
`default_nettype none
// Latch-high status bit: event sets, host read clears, set wins a tie
module anreg_latch_high (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic event_in,
	input  wire logic read_clr,
	output logic      flag
);
	import anreg_pkg::*;

	logic flag_ff;
	logic nxt_flag;

	assign nxt_flag = event_in | (flag_ff & ~read_clr);
	assign flag = flag_ff;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			flag_ff <= RST_EXTRA_STATUS[POS_PAGE_SEEN];
		end else begin
			flag_ff <= nxt_flag;
		end
	end
endmodule // anreg_latch_high
`default_nettype wire

// ---- verification/anreg_status_id_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module anreg_status_id_properties
	import anreg_pkg::*;
#(
	parameter logic [15:0] VENDOR_ID_HIGH = 16'h0000
) (
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	input wire logic        mgmt_rd,
	input wire logic [4:0]  mgmt_devad,
	input wire logic [15:0] mgmt_addr,
	input wire logic [15:0] mgmt_rdata,
	input wire logic        mgmt_hit,
	input wire logic        partner_page_request_evt,
	input wire logic        good_check_entry,
	input wire logic        priority_incompatible,
	input wire logic        partner_page_request_seen,
	input wire logic        incompatible_link_flag
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	wire st_rd = mgmt_rd && mgmt_devad == DEVAD_AN
		&& mgmt_addr == OFS_EXTRA_STATUS;
	wire id_rd = mgmt_rd && mgmt_devad == DEVAD_VEND
		&& mgmt_addr == OFS_VENDOR_ID_HIGH;
	sequence s_st_rd;
		st_rd;
	endsequence
	sequence s_evt;
		partner_page_request_evt;
	endsequence
	a_status_hit: assert property (s_st_rd |=> mgmt_hit
		&& mgmt_rdata[15:9] == 7'h00) else $error("status read");
	a_seen_readback: assert property (s_st_rd |=>
		mgmt_rdata[8] == $past(partner_page_request_seen)) else $error("bit8");
	a_event_sets: assert property (s_evt |=>
		partner_page_request_seen) else $error("seen not set");
	a_latch_holds: assert property (partner_page_request_seen
		&& !st_rd |=> partner_page_request_seen) else $error("seen lost");
	a_incompat_load: assert property (good_check_entry |=>
		incompatible_link_flag == $past(priority_incompatible))
		else $error("bit7 load");
	a_incompat_hold: assert property (!good_check_entry |=>
		$stable(incompatible_link_flag)) else $error("bit7 moved");
	a_vendor_high: assert property (id_rd |=> mgmt_hit
		&& mgmt_rdata == VENDOR_ID_HIGH) else $error("id word");
	a_rdata_hold: assert property (!mgmt_rd |=>
		$stable(mgmt_rdata)) else $error("rdata moved");
endmodule // anreg_status_id_properties
bind anreg_status_id anreg_status_id_properties #(
	.VENDOR_ID_HIGH(VENDOR_ID_HIGH)
) u_props (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .mgmt_rd(mgmt_rd),
	.mgmt_devad(mgmt_devad), .mgmt_addr(mgmt_addr),
	.mgmt_rdata(mgmt_rdata), .mgmt_hit(mgmt_hit),
	.partner_page_request_evt(partner_page_request_evt),
	.good_check_entry(good_check_entry),
	.priority_incompatible(priority_incompatible),
	.partner_page_request_seen(partner_page_request_seen),
	.incompatible_link_flag(incompatible_link_flag)
);
`default_nettype wire

// ---- verification/anreg_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module anreg_host_model (
	input wire logic         ref_clk,
	output logic             mgmt_rd,
	output logic             mgmt_wr,
	output logic [4:0]       mgmt_devad,
	output logic [15:0]      mgmt_addr,
	output logic [15:0]      mgmt_wdata,
	input wire logic [15:0]  mgmt_rdata,
	input wire logic         mgmt_hit
);
	initial begin
		mgmt_rd = 1'b0;
		mgmt_wr = 1'b0;
		mgmt_devad = 5'h00;
		mgmt_addr = 16'h0000;
		mgmt_wdata = 16'h0000;
	end
	task access(input logic wr, input logic [4:0] dv,
		input logic [15:0] ad, output logic [15:0] d, output logic h);
		@(negedge ref_clk);
		mgmt_rd = !wr;
		mgmt_wr = wr;
		mgmt_devad = dv;
		mgmt_addr = ad;
		mgmt_wdata = 16'($urandom);
		@(negedge ref_clk);
		mgmt_rd = 1'b0;
		mgmt_wr = 1'b0;
		// Released lines flip so a stale address never looks valid
		mgmt_devad = ~dv;
		mgmt_addr = ~ad;
		d = mgmt_rdata;
		h = mgmt_hit;
	endtask
endmodule // anreg_host_model
`default_nettype wire

// ---- verification/anreg_status_id_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module anreg_status_id_tb;
	import anreg_pkg::*;
	localparam logic [15:0] IDH = 16'h5a3c; // Arbitrary value
	localparam logic [9:0] IDL = 10'h0b3; // Arbitrary value
	logic ref_clk = 1'b0, sys_rst = 1'b1, rd, wr, hit, seen, inc;
	logic evt = 1'b0, entry = 1'b0, prio = 1'b0, lg = 1'b0;
	logic [1:0] role = 2'h0;
	logic [3:0] tech = 4'h0;
	logic [4:0] dv;
	logic [15:0] ad, wd, rdata, d, snap, live = 16'h0000;
	int n_fail = 0, comparisons = 0, e_seen = 0, e_inc = 0;
	always #5 ref_clk = ~ref_clk;
	anreg_status_id #(.VENDOR_ID_HIGH(IDH), .VENDOR_ID_LOW(IDL[9:4]),
		.MODEL_NUMBER({2'h0, IDL[3:0]}), .REVISION(4'h9)) dut (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .mgmt_rd(rd), .mgmt_wr(wr),
		.mgmt_devad(dv), .mgmt_addr(ad), .mgmt_wdata(wd),
		.mgmt_rdata(rdata), .mgmt_hit(hit),
		.partner_unformatted_field_two(live),
		.partner_page_request_evt(evt), .good_check_entry(entry),
		.priority_incompatible(prio), .role_resolution_in(role),
		.common_technology_in(tech), .negotiation_link_good_in(lg),
		.partner_page_request_seen(seen), .incompatible_link_flag(inc));
	anreg_host_model host (.ref_clk(ref_clk), .mgmt_rd(rd), .mgmt_wr(wr),
		.mgmt_devad(dv), .mgmt_addr(ad), .mgmt_wdata(wd),
		.mgmt_rdata(rdata), .mgmt_hit(hit));
	task cmp(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	task r(input logic [4:0] v, input logic [15:0] a, input logic w = 0);
		logic h;
		host.access(w, v, a, d, h);
		comparisons++;
		// A write still reports whether it addressed this block
		if (h !== ((v == DEVAD_AN && (a == OFS_PARTNER_NP_UPPER
			|| a == OFS_EXTRA_STATUS)) || (v == DEVAD_VEND
			&& (a == OFS_VENDOR_ID_HIGH || a == OFS_VENDOR_ID_LOW)))) begin
			n_fail++;
			$display("MISMATCH %0t hit flag", $time);
		end
	endtask
	function logic [15:0] st();
		return {7'h00, e_seen[0], e_inc[0], role, tech, lg};
	endfunction
	task complete_run;
		if (n_fail == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		complete_run;
	end
	initial begin
		void'($urandom(32'h0cd2));
		repeat (5) @(negedge ref_clk);
		sys_rst = 1'b0;
		r(DEVAD_AN, OFS_EXTRA_STATUS);
		cmp(d, RST_EXTRA_STATUS);
		for (int i = 0; i < 8; i++) begin
			role = i[1:0];
			tech = i[2] ? TECH_T1L : TECH_NULL;
			lg = 1'($urandom);
			r(DEVAD_AN, OFS_EXTRA_STATUS);
			cmp(d, st());
		end
		@(negedge ref_clk) evt = 1'b1;
		@(negedge ref_clk) evt = 1'b0;
		e_seen = 1;
		repeat (3) @(negedge ref_clk);
		cmp(16'(seen), 16'h0001);
		r(DEVAD_AN, OFS_EXTRA_STATUS);
		cmp(d, st());
		e_seen = 0;
		prio = 1'b1;
		r(DEVAD_AN, OFS_EXTRA_STATUS);
		cmp(d, st());
		@(negedge ref_clk) entry = 1'b1;
		@(negedge ref_clk) entry = 1'b0;
		prio = 1'b0;
		e_inc = 1;
		r(DEVAD_AN, OFS_EXTRA_STATUS, 1'b1);
		r(DEVAD_AN, OFS_EXTRA_STATUS);
		cmp(d, st());
		live = 16'($urandom);
		snap = live;
		r(DEVAD_AN, OFS_PARTNER_NP_LOWER);
		live = ~snap;
		r(DEVAD_AN, OFS_PARTNER_NP_UPPER);
		cmp(d, snap);
		r(DEVAD_VEND, OFS_VENDOR_ID_HIGH, 1'b1);
		r(DEVAD_VEND, OFS_VENDOR_ID_HIGH);
		cmp(d, IDH);
		r(DEVAD_VEND, OFS_VENDOR_ID_LOW);
		cmp(d, {IDL[9:4], 2'h0, IDL[3:0], 4'h9});
		r(DEVAD_AN, 16'h0002);
		cmp(d, RD_UNMAPPED);
		complete_run;
	end
endmodule // anreg_status_id_tb
`default_nettype wire
